// ===== bench/miop_ext_pins.sv
// Model of port pins with pull-ups and external pull-low switches
`timescale 1ns/10ps
`default_nettype none
module miop_ext_pins #(
	parameter int W = 4 // Pin count
) (
	input  wire logic [W-1:0] i_oe,   // Device pulls low while high
	input  wire logic [W-1:0] i_pull, // External pull-low switch
	output logic      [W-1:0] o_pin   // Wire level seen by device
);
	// Open drain wire: the pull-up wins only when nobody pulls low
	assign o_pin = ~(i_oe | i_pull);
endmodule // miop_ext_pins
`default_nettype wire

// ===== bench/miop_port_set_sva.sv
// Checker of pin and latch timing relations of the port set
`timescale 1ns/10ps
`default_nettype none
module miop_port_set_sva (
	input wire logic                i_clk,               // Core clock
	input wire logic                i_rst,               // Sync reset
	input wire miop_pkg::miop_req_t i_req,               // Core access
	input wire logic [7:0]          i_conv_byte,         // Conversion byte
	input wire logic [3:0]          o_output_port_low,   // Low nibble
	input wire logic [3:0]          o_output_port_high,  // High nibble
	input wire logic [3:0]          o_pwm_pin_oe,        // Pwm pull-low
	input wire logic                i_fine_dac_output,   // Fine DAC
	input wire logic [2:0]          i_coarse_dac_output, // Coarse DACs
	input wire logic [3:0]          i_irq_pin,           // Irq pins
	input wire logic [3:0]          o_irq_pin_oe,        // Irq pull-low
	input wire logic [2:0]          o_cmp_pin_oe,        // Comparator pull-low
	input wire miop_pkg::miop_alt_t o_alt                // Peripheral inputs
);
	import miop_pkg::*;
	logic [1:0] rst_hist_ff; // Reset history, the synchronisers refill after release
	always_ff @(posedge i_clk) rst_hist_ff <= {rst_hist_ff[0], i_rst};
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_byte_split: assert property (i_req.op == OP_BYTE |=>
		{o_output_port_high, o_output_port_low} == $past(i_conv_byte)) else $error("byte not split");
	a_reset_ones: assert property (disable iff (1'b0) i_rst |=> o_cmp_pin_oe == 3'h0 &&
		o_pwm_pin_oe == ~{i_coarse_dac_output, i_fine_dac_output}) else $error("latch not one");
	a_fine_dac: assert property (!o_pwm_pin_oe[0] |-> i_fine_dac_output) else $error("fine dac");
	a_coarse_dac: assert property ((~o_pwm_pin_oe[3:1] & ~i_coarse_dac_output) == 3'h0)
		else $error("coarse dac");
	a_irq_set: assert property (i_req.op == OP_SET && i_req.sel == SEL_IRQ |=>
		o_irq_pin_oe == ($past(o_irq_pin_oe) & ~(4'h1 << $past(i_req.bit_idx)))) else $error("set bit");
	a_irq_clear: assert property (i_req.op == OP_CLR && i_req.sel == SEL_IRQ |=>
		o_irq_pin_oe == ($past(o_irq_pin_oe) | (4'h1 << $past(i_req.bit_idx)))) else $error("clear bit");
	a_cmp_clear: assert property (i_req.op == OP_CLR && i_req.sel == SEL_CMP && i_req.bit_idx == 2'h2
		|=> o_cmp_pin_oe[2]) else $error("cmp clear");
	a_irq_route: assert property (rst_hist_ff == 2'b00 |-> {o_alt.counter_one_event_in,
		o_alt.ext_irq_one_in, o_alt.counter_two_event_in, o_alt.ext_irq_two_in} == $past(i_irq_pin, 2))
		else $error("irq route");
	c_byte: cover property (i_req.op == OP_BYTE);
	c_irq_clr: cover property (i_req.op == OP_CLR && i_req.sel == SEL_IRQ);
	c_cmp_clr: cover property (i_req.op == OP_CLR && i_req.sel == SEL_CMP);
endmodule // miop_port_set_sva
bind miop_port_set miop_port_set_sva u_sva (.i_clk, .i_rst, .i_req, .i_conv_byte, .o_output_port_low,
	.o_output_port_high, .o_pwm_pin_oe, .i_fine_dac_output, .i_coarse_dac_output, .i_irq_pin,
	.o_irq_pin_oe, .o_cmp_pin_oe, .o_alt);
`default_nettype wire

// ===== bench/miop_port_set_test.sv
// Self-checking bench of the I/O port set
`timescale 1ns/10ps
`default_nettype none
module miop_port_set_test;
	import miop_pkg::*;
	typedef struct {logic ck; logic [3:0] rd; logic [7:0] ob;} miop_exp_t;
	logic       i_clk, i_rst, live, fine, hold, tk;
	logic [2:0] coarse, cpin, cpo, pcmp, cdrv;
	logic [3:0] rdata, olo, ohi, din, ppin, ppo, pirq, ipin, ipo, ppwm, irqm, pdrv, idrv;
	logic [7:0] conv, ob, cb;
	miop_req_t  req;
	miop_alt_t  alt;
	miop_exp_t  q[$];
	miop_exp_t  e;
	int         fail_count, samples_checked, k;
	int         seed = 32'h5fc1237d;

	miop_port_set DUT (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_conv_byte(conv), .o_rdata(rdata),
		.i_dedicated_input_port(din), .o_output_port_low(olo), .o_output_port_high(ohi),
		.i_pwm_pin(ppin), .o_pwm_pin(pdrv), .o_pwm_pin_oe(ppo), .i_fine_dac_output(fine),
		.i_coarse_dac_output(coarse), .i_irq_pin(ipin), .o_irq_pin(idrv), .o_irq_pin_oe(ipo),
		.i_cmp_pin(cpin), .o_cmp_pin(cdrv), .o_cmp_pin_oe(cpo), .i_hold_pin(hold), .o_alt(alt));
	miop_ext_pins #(.W(4)) u_pwm (.i_oe(ppo), .i_pull(ppwm), .o_pin(ppin));
	miop_ext_pins #(.W(4)) u_irq (.i_oe(ipo), .i_pull(pirq), .o_pin(ipin));
	miop_ext_pins #(.W(3)) u_cmp (.i_oe(cpo), .i_pull(pcmp), .o_pin(cpin));

	// Clock and time-zero values
	initial begin
		{i_rst, fine, hold, coarse, irqm} = {3'h7, 3'h7, 4'hf};
		{live, req, din, ppwm, pirq, pcmp, conv, ob, cb} = '0;
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// One core access per edge; the expected answer goes on the queue
	task automatic drv(input miop_op_t op, input logic [2:0] sel, input logic [1:0] b, input logic ck,
		input logic [3:0] rd);
		@(posedge i_clk);
		req <= '{op, sel, cb[3:0], b, 5'h00};
		conv <= cb;
		live <= 1'b1;
		if (op == OP_BYTE) ob = cb;
		if (sel == SEL_IRQ && op == OP_SET) irqm[b] = 1'b1;
		if (sel == SEL_IRQ && op == OP_CLR) irqm[b] = 1'b0;
		q.push_back('{ck, rd, ob});
	endtask

	task automatic idle(input int n);
		repeat (n) begin
			@(posedge i_clk);
			live <= 1'b0;
			req.op <= OP_NONE;
		end
	endtask

	task automatic summarize();
		$display("checked %0d, failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Monitor: results of each taken access settle one edge later
	always @(posedge i_clk) begin
		tk = live;
		#1;
		if (tk && q.size() > 0) begin
			e = q.pop_front();
			if (e.ck) chk({4'h0, rdata}, {4'h0, e.rd});
			chk({ohi, olo}, e.ob);
		end
	end

	// Watchdog, well beyond the roughly 57 cycles of the sequence
	initial begin
		repeat (2000) @(posedge i_clk);
		fail_count++;
		summarize();
	end

	initial begin
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		drv(OP_NONE, SEL_PWM, 2'h0, 1'b1, 4'hf);
		drv(OP_NONE, SEL_CMP, 2'h0, 1'b1, 4'h7);
		for (k = 0; k < 4; k++) begin
			cb = $random(seed);
			drv(OP_BYTE, SEL_OLOW, 2'h0, 1'b0, 4'h0);
		end
		drv(OP_WRITE, SEL_IN0, 2'h0, 1'b0, 4'h0);
		for (k = 0; k < 12; k++) begin
			cb = $random(seed);
			drv(cb[0] ? OP_SET : OP_CLR, SEL_IRQ, cb[2:1], 1'b0, 4'h0);
		end
		idle(3);
		drv(OP_NONE, SEL_IRQ, 2'h0, 1'b1, irqm);
		cb = $random(seed);
		din <= cb[7:4];
		idle(3);
		drv(OP_NONE, SEL_IN0, 2'h0, 1'b1, cb[7:4]);
		for (k = 0; k < 4; k++) drv(OP_SET, SEL_IRQ, k[1:0], 1'b0, 4'h0);
		pirq <= 4'h4;
		idle(3);
		drv(OP_NONE, SEL_IRQ, 2'h0, 1'b1, 4'hb);
		idle(1);
		chk({4'h0, alt[5:2]}, 8'h0b);
		for (k = 0; k < 4; k++) begin
			cb = $random(seed);
			@(posedge i_clk);
			{coarse, fine} <= cb[3:0];
			#2;
			chk({4'h0, ppo}, {4'h0, ~cb[3:0]});
		end
		// A cleared latch must hold the pin low whatever the DAC does
		drv(OP_CLR, SEL_PWM, 2'h0, 1'b0, 4'h0);
		fine <= 1'b1;
		idle(1);
		#2;
		chk({7'h0, ppo[0]}, 8'h01);
		chk({pdrv, idrv}, 8'h00);
		chk({5'h0, cdrv}, 8'h00);
		hold <= 1'b0;
		pcmp <= 3'h4;
		idle(3);
		chk({6'h0, alt.comparator_input, alt.hold_req}, 8'h00);
		pcmp <= 3'h0;
		drv(OP_CLR, SEL_CMP, 2'h2, 1'b0, 4'h0);
		drv(OP_SET, SEL_CMP, 2'h3, 1'b0, 4'h0);
		idle(3);
		drv(OP_NONE, SEL_CMP, 2'h0, 1'b1, 4'h3);
		drv(OP_NONE, SEL_HOLD, 2'h0, 1'b1, 4'h0);
		idle(2);
		summarize();
	end
endmodule // miop_port_set_test
`default_nettype wire

// ===== src/miop_bitlatch.sv
// One bidirectional port latch with bit set/clear and open-drain pin drive
`timescale 1ns/10ps
`default_nettype none
module miop_bitlatch #(
	parameter int          W       = 4,          // Port width
	parameter logic [W-1:0] RST_VAL = '1         // Latch value at reset
) (
	input  wire logic         i_clk,      // Core clock
	input  wire logic         i_rst,      // Sync reset, active high
	input  wire logic         i_wr,       // Whole-port write
	input  wire logic [W-1:0] i_wdata,    // Whole-port data
	input  wire logic         i_set,      // Set one bit
	input  wire logic         i_clr,      // Clear one bit
	input  wire logic [1:0]   i_bit,      // Bit index
	input  wire logic [W-1:0] i_alt,      // Alternate drive, one = release
	output logic      [W-1:0] o_latch,    // Latch contents
	output logic      [W-1:0] o_pin_oe    // Pin pulled low while high
);
	logic [W-1:0] latch_ff;
	logic [W-1:0] nxt_latch;

	// Whole-port write or single-bit update
	always_comb begin
		nxt_latch = latch_ff;
		if (i_wr) begin
			nxt_latch = i_wdata;
		end else if (i_set && (32'(i_bit) < W)) begin
			nxt_latch[i_bit] = 1'b1;
		end else if (i_clr && (32'(i_bit) < W)) begin
			nxt_latch[i_bit] = 1'b0;
		end
	end

	// Latch register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			latch_ff <= RST_VAL;
		end else begin
			latch_ff <= nxt_latch;
		end
	end

	assign o_latch  = latch_ff;
	// Open drain: a zero in latch or alternate source pulls low; a one leaves pin to sense
	assign o_pin_oe = ~(latch_ff & i_alt);
endmodule // miop_bitlatch
`default_nettype wire

// ===== src/miop_pkg.sv
// Package of constants and carriers for the I/O port set
package miop_pkg;
	localparam int NIB_W      = 4;            // Port width
	localparam int CMP_W      = 3;            // Comparator port width
	localparam int SRC5_W     = 5;            // Conversion input width
	localparam int PORT_SEL_W = 3;            // Port select width

	// Port selectors for core accesses
	localparam logic [2:0] SEL_IN0  = 3'h0;   // Dedicated input port
	localparam logic [2:0] SEL_OLOW = 3'h1;   // Output port low
	localparam logic [2:0] SEL_OHI  = 3'h2;   // Output port high
	localparam logic [2:0] SEL_PWM  = 3'h4;   // Pulse-width shared port
	localparam logic [2:0] SEL_IRQ  = 3'h5;   // Irq/counter shared port
	localparam logic [2:0] SEL_CMP  = 3'h6;   // Comparator shared port
	localparam logic [2:0] SEL_HOLD = 3'h7;   // Hold sense bit

	// Reset values
	localparam logic [3:0] RST_NIB_ONES = 4'hf;
	localparam logic [2:0] RST_CMP_ONES = 3'h7;
	localparam logic [3:0] RST_OUT_NIB  = 4'h0;

	// Bit positions on the shared ports
	localparam int BIT_FINE      = 0;
	localparam int BIT_CNT1      = 3;
	localparam int BIT_IRQ1      = 2;
	localparam int BIT_CNT2      = 1;
	localparam int BIT_IRQ2      = 0;
	localparam int BIT_CMP_INPUT = 2;

	// Core write operations
	typedef enum logic [2:0] {
		OP_NONE  = 3'b000,
		OP_WRITE = 3'b001,
		OP_SET   = 3'b010,
		OP_CLR   = 3'b011,
		OP_BYTE  = 3'b100
	} miop_op_t;

	// One core access
	typedef struct packed {
		miop_op_t       op;    // Operation
		logic [2:0]     sel;   // Port select
		logic [3:0]     data;  // Nibble data
		logic [1:0]     bit_idx; // Bit index, may come from a register
		logic [4:0]     src5;  // Conversion source
	} miop_req_t;

	// Alternate-function inputs seen by peripherals
	typedef struct packed {
		logic counter_one_event_in;
		logic ext_irq_one_in;
		logic counter_two_event_in;
		logic ext_irq_two_in;
		logic comparator_input;
		logic hold_req;
	} miop_alt_t;
endpackage

// ===== src/miop_port_set.sv
// Top of the microcontroller I/O port set
`timescale 1ns/10ps
`default_nettype none
module miop_port_set (
	input  wire logic                i_clk,          // Core clock, 25 MHz
	input  wire logic                i_rst,          // Sync reset, active high
	input  wire miop_pkg::miop_req_t i_req,          // Core port access
	input  wire logic [7:0]          i_conv_byte,    // 5-to-8 conversion table result
	output logic      [3:0]          o_rdata,        // Read data of selected port
	input  wire logic [3:0]          i_dedicated_input_port, // Input-only pins
	output logic      [3:0]          o_output_port_low,      // Low nibble output pins
	output logic      [3:0]          o_output_port_high,     // High nibble output pins
	input  wire logic [3:0]          i_pwm_pin,      // Pulse-width port pin levels
	output logic      [3:0]          o_pwm_pin,      // Pulse-width port drive (always 0)
	output logic      [3:0]          o_pwm_pin_oe,   // Pulse-width port pull-low enable
	input  wire logic                i_fine_dac_output,      // Fine DAC waveform
	input  wire logic [2:0]          i_coarse_dac_output,    // Coarse DAC waveforms
	input  wire logic [3:0]          i_irq_pin,      // Irq/counter port pin levels
	output logic      [3:0]          o_irq_pin,      // Irq/counter port drive (always 0)
	output logic      [3:0]          o_irq_pin_oe,   // Irq/counter port pull-low enable
	input  wire logic [2:0]          i_cmp_pin,      // Comparator port pin levels
	output logic      [2:0]          o_cmp_pin,      // Comparator port drive (always 0)
	output logic      [2:0]          o_cmp_pin_oe,   // Comparator port pull-low enable
	input  wire logic                i_hold_pin,     // Hold request pin
	output miop_pkg::miop_alt_t      o_alt           // Inputs to peripherals
);
	import miop_pkg::*;

	// Two-stage synchronisers on every pin input
	logic [3:0] k_s1_ff, k_s2_ff, pwm_s1_ff, pwm_s2_ff, irq_s1_ff, irq_s2_ff;
	logic [2:0] cmp_s1_ff, cmp_s2_ff;
	logic       hold_s1_ff, hold_s2_ff;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			{k_s1_ff, k_s2_ff, pwm_s1_ff, pwm_s2_ff} <= 16'hffff;
			{irq_s1_ff, irq_s2_ff}                   <= 8'hff;
			{cmp_s1_ff, cmp_s2_ff}                   <= 6'h3f;
			{hold_s1_ff, hold_s2_ff}                 <= 2'h3;
		end else begin
			k_s1_ff    <= i_dedicated_input_port;
			k_s2_ff    <= k_s1_ff;
			pwm_s1_ff  <= i_pwm_pin;
			pwm_s2_ff  <= pwm_s1_ff;
			irq_s1_ff  <= i_irq_pin;
			irq_s2_ff  <= irq_s1_ff;
			cmp_s1_ff  <= i_cmp_pin;
			cmp_s2_ff  <= cmp_s1_ff;
			hold_s1_ff <= i_hold_pin;
			hold_s2_ff <= hold_s1_ff;
		end
	end

	// Output ports: whole-nibble writes or the converted byte at once
	logic [3:0] out_low_ff, out_high_ff;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			out_low_ff  <= RST_OUT_NIB;
			out_high_ff <= RST_OUT_NIB;
		end else if (i_req.op == OP_BYTE) begin
			// Both nibbles update in the same edge so the byte is never torn
			out_low_ff  <= i_conv_byte[3:0];
			out_high_ff <= i_conv_byte[7:4];
		end else if (i_req.op == OP_WRITE && i_req.sel == SEL_OLOW) begin
			out_low_ff  <= i_req.data;
		end else if (i_req.op == OP_WRITE && i_req.sel == SEL_OHI) begin
			out_high_ff <= i_req.data;
		end
	end

	assign o_output_port_low  = out_low_ff;
	assign o_output_port_high = out_high_ff;

	// Decode of per-port strobes
	logic wr_pwm, wr_irq, wr_cmp;
	logic set_op, clr_op;

	assign wr_pwm = (i_req.op == OP_WRITE) && (i_req.sel == SEL_PWM);
	assign wr_irq = (i_req.op == OP_WRITE) && (i_req.sel == SEL_IRQ);
	assign wr_cmp = (i_req.op == OP_WRITE) && (i_req.sel == SEL_CMP);
	assign set_op = (i_req.op == OP_SET);
	assign clr_op = (i_req.op == OP_CLR);

	// Alternate drive per pin; one means the alternate function releases the pin
	logic [3:0] pwm_alt;
	logic [3:0] pwm_latch, irq_latch;
	logic [2:0] cmp_latch;

	assign pwm_alt[BIT_FINE] = i_fine_dac_output;
	assign pwm_alt[3:1]      = i_coarse_dac_output;

	// Pulse-width shared port; DAC only reaches the pin while latch is one
	miop_bitlatch #(
		.W       (NIB_W),
		.RST_VAL (RST_NIB_ONES)
	) u_pwm (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_wr    (wr_pwm),
		.i_wdata (i_req.data),
		.i_set   (set_op && i_req.sel == SEL_PWM),
		.i_clr   (clr_op && i_req.sel == SEL_PWM),
		.i_bit   (i_req.bit_idx),
		.i_alt   (pwm_alt),
		.o_latch (pwm_latch),
		.o_pin_oe(o_pwm_pin_oe)
	);

	// Irq/counter shared port; no alternate output, pins only sensed
	miop_bitlatch #(
		.W       (NIB_W),
		.RST_VAL (RST_NIB_ONES)
	) u_irq (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_wr    (wr_irq),
		.i_wdata (i_req.data),
		.i_set   (set_op && i_req.sel == SEL_IRQ),
		.i_clr   (clr_op && i_req.sel == SEL_IRQ),
		.i_bit   (i_req.bit_idx),
		.i_alt   (RST_NIB_ONES),
		.o_latch (irq_latch),
		.o_pin_oe(o_irq_pin_oe)
	);

	// Comparator shared port, three bits
	miop_bitlatch #(
		.W       (CMP_W),
		.RST_VAL (RST_CMP_ONES)
	) u_cmp (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_wr    (wr_cmp),
		.i_wdata (i_req.data[2:0]),
		.i_set   (set_op && i_req.sel == SEL_CMP),
		.i_clr   (clr_op && i_req.sel == SEL_CMP),
		.i_bit   (i_req.bit_idx),
		.i_alt   (RST_CMP_ONES),
		.o_latch (cmp_latch),
		.o_pin_oe(o_cmp_pin_oe)
	);

	// Open-drain: drive value is always low, enable decides
	assign o_pwm_pin = 4'h0;
	assign o_irq_pin = 4'h0;
	assign o_cmp_pin = 3'h0;

	// Peripheral inputs from synchronised pins; software keeps latches at one
	always_comb begin
		o_alt.counter_one_event_in = irq_s2_ff[BIT_CNT1];
		o_alt.ext_irq_one_in       = irq_s2_ff[BIT_IRQ1];
		o_alt.counter_two_event_in = irq_s2_ff[BIT_CNT2];
		o_alt.ext_irq_two_in       = irq_s2_ff[BIT_IRQ2];
		o_alt.comparator_input     = cmp_s2_ff[BIT_CMP_INPUT];
		o_alt.hold_req             = hold_s2_ff;
	end

	// Read mux; a pin reads low when the latch or outside logic pulls it down
	logic [3:0] nxt_rdata;
	logic [3:0] rdata_ff;

	always_comb begin
		if (i_req.sel == SEL_IN0) begin
			nxt_rdata = k_s2_ff;
		end else if (i_req.sel == SEL_OLOW) begin
			nxt_rdata = out_low_ff;
		end else if (i_req.sel == SEL_OHI) begin
			nxt_rdata = out_high_ff;
		end else if (i_req.sel == SEL_PWM) begin
			nxt_rdata = pwm_s2_ff & pwm_latch;
		end else if (i_req.sel == SEL_IRQ) begin
			nxt_rdata = irq_s2_ff & irq_latch;
		end else if (i_req.sel == SEL_CMP) begin
			nxt_rdata = {1'b0, cmp_s2_ff & cmp_latch};
		end else begin
			nxt_rdata = {3'h0, hold_s2_ff};
		end
	end

	// Registered read data, one cycle after the select
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_ff <= RST_OUT_NIB;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign o_rdata = rdata_ff;
endmodule // miop_port_set
`default_nettype wire
